/* File: pkg/dcbr_pkg.sv */
// Purpose: Shared constants and types of the dual clock block memory.
// Assumes: One system clock samples the port clocks of the array.
// Notes:   Every shape holds the same number of storage bits.
package dcbr_pkg;

   // Storage per block, identical for every shape
   localparam int TOTAL_BITS  = 4096;
   // Data widths of the four shapes
   localparam int WIDTH_X16   = 16;
   localparam int WIDTH_X8    = 8;
   localparam int WIDTH_X4    = 4;
   localparam int WIDTH_X2    = 2;
   // Only the widest shape carries a bit mask
   localparam int MASK_WIDTH  = 16;
   // Depth of the pin synchronisers
   localparam int SYNC_STAGES = 2;
   // Mask bit meaning: zero writes the bit, one keeps it
   localparam logic MASK_WRITE = 1'h0;
   // Reset value of the read data register
   localparam logic [15:0] RD_RESET = 16'h0000;

   // Edge choice of the two port clocks
   typedef enum {
      VAR_PLAIN,
      VAR_FALL_READ,
      VAR_FALL_WRITE,
      VAR_FALL_BOTH
   } dcbr_variant_t;

endpackage : dcbr_pkg

/* File: src/dcbr_block_ram.sv */
// Purpose: 4-kbit block memory with separate write and read ports.
// Assumes: Port clocks and controls come from pins; clk is far faster.
// Notes:   Port levels must stay at least two clk periods each.
//
// Summary of operation
// - Serves as single-port, pseudo dual-port, or FIFO storage.
// - Shapes 256x16, 512x8, 1024x4, 2048x2; address widths 8 to 11.
// - Every shape holds exactly four kilobits.
// - In the 16-bit shape a mask zero writes a bit, one keeps it.
// - Write address picks the word written.
// - Read address picks the word shown on read data.
// - Addresses and data are registered at the array on port edges.
// - Plain variant uses rising edges of both port clocks.
// - Falling-read variant writes on rising, reads on falling edges.
// - Falling-write and both-falling variants invert the named clocks.
// - Write clock rises by default, falling edge selectable at build.
// - Read clock rises by default, falling edge selectable at build.
// - Contents may be preloaded before user operation.
`timescale 1ns/1ps

module dcbr_block_ram
   import dcbr_pkg::*;
#(
   parameter int                    DATA_W     = WIDTH_X16,
   parameter dcbr_variant_t         VARIANT    = VAR_PLAIN,
   parameter logic [TOTAL_BITS-1:0] INIT_IMAGE = '0,
   localparam int                   DEPTH      = TOTAL_BITS / DATA_W,
   localparam int                   ADDR_W     = $clog2(DEPTH)
) (
   input  wire logic              clk,
   input  wire logic              srst,
   input  wire logic              wrClock,
   input  wire logic              wrClockGate,
   input  wire logic              wrEnable,
   input  wire logic [ADDR_W-1:0] wrLocation,
   input  wire logic [DATA_W-1:0] wrData,
   input  wire logic [DATA_W-1:0] wrMask,
   input  wire logic              rdClock,
   input  wire logic              rdClockGate,
   input  wire logic              rdEnable,
   input  wire logic [ADDR_W-1:0] rdLocation,
   output logic      [DATA_W-1:0] rdData
);

   // Shape and edge choices, fixed at build time
   localparam bit HAS_MASK = (DATA_W == MASK_WIDTH);
   localparam bit WR_FALL  = (VARIANT == VAR_FALL_WRITE)
                          || (VARIANT == VAR_FALL_BOTH);
   localparam bit RD_FALL  = (VARIANT == VAR_FALL_READ)
                          || (VARIANT == VAR_FALL_BOTH);
   localparam int WV       = 3 + ADDR_W + 2 * DATA_W;
   localparam int RV       = 3 + ADDR_W;

   // Refuse shapes the array cannot take
   if (!(DATA_W inside {WIDTH_X16, WIDTH_X8, WIDTH_X4, WIDTH_X2})) begin : g_bad_w
      $error("dcbr_block_ram: unsupported data width");
   end
   if (DEPTH * DATA_W != TOTAL_BITS) begin : g_bad_size
      $error("dcbr_block_ram: storage is not four kilobits");
   end
   if (SYNC_STAGES != 2) begin : g_bad_sync
      $error("dcbr_block_ram: synchroniser depth must be two");
   end

   typedef logic [DATA_W-1:0] dcbr_mem_t [DEPTH];

   // Selected edge of a synchronised clock level
   function automatic logic edgeHit(input logic prev,
                                    input logic cur,
                                    input logic fall);
      edgeHit = fall ? (prev && !cur) : (!prev && cur);
   endfunction : edgeHit

   // Preload image, word i taken from bits i*DATA_W upward
   function automatic dcbr_mem_t initImage();
      dcbr_mem_t img;
      for (int i = 0; i < DEPTH; i++) begin
         img[i] = INIT_IMAGE[i*DATA_W +: DATA_W];
      end
      initImage = img;
   endfunction : initImage

   // Array holds its contents through srst, like configured storage
   dcbr_mem_t mem = initImage();

   logic [WV-1:0]     wrSync1_r;
   logic [WV-1:0]     wrSync2_r;
   logic              wrPrev_r;
   logic [RV-1:0]     rdSync1_r;
   logic [RV-1:0]     rdSync2_r;
   logic              rdPrev_r;
   logic              wrClkS;
   logic              wrGateS;
   logic              wrEnS;
   logic [ADDR_W-1:0] wrAddrS;
   logic [DATA_W-1:0] wrDataS;
   logic [DATA_W-1:0] wrMaskS;
   logic              rdClkS;
   logic              rdGateS;
   logic              rdEnS;
   logic [ADDR_W-1:0] rdAddrS;
   logic              wrHit;
   logic              rdHit;
   logic              wrFire;
   logic              rdFire;
   logic              wrGo_r;
   logic [ADDR_W-1:0] wrAddr_r;
   logic [DATA_W-1:0] wrData_r;
   logic [DATA_W-1:0] wrMask_r;
   logic              rdGo_r;
   logic [ADDR_W-1:0] rdAddr_r;
   logic [DATA_W-1:0] rdData_r;
   logic [DATA_W-1:0] wrPeek;
   logic [DATA_W-1:0] rdPeek;
   logic [DATA_W-1:0] wrWord;

   // Two-stage synchronisers; the first stage feeds only the second
   always_ff @(posedge clk) begin
      if (srst) begin
         wrSync1_r <= '0;
         wrSync2_r <= '0;
         rdSync1_r <= '0;
         rdSync2_r <= '0;
      end else begin
         wrSync1_r <= {wrClock, wrClockGate, wrEnable, wrLocation, wrData, wrMask};
         wrSync2_r <= wrSync1_r;
         rdSync1_r <= {rdClock, rdClockGate, rdEnable, rdLocation};
         rdSync2_r <= rdSync1_r;
      end
   end

   // Clocks and data pass the same stages, so they stay aligned
   assign {wrClkS, wrGateS, wrEnS, wrAddrS, wrDataS, wrMaskS} = wrSync2_r;
   assign {rdClkS, rdGateS, rdEnS, rdAddrS} = rdSync2_r;

   // Previous clock levels for edge detection
   always_ff @(posedge clk) begin
      if (srst) begin
         wrPrev_r <= 1'h0;
         rdPrev_r <= 1'h0;
      end else begin
         wrPrev_r <= wrClkS;
         rdPrev_r <= rdClkS;
      end
   end

   // Edge polarity per variant
   assign wrHit  = edgeHit(wrPrev_r, wrClkS, WR_FALL);
   assign rdHit  = edgeHit(rdPrev_r, rdClkS, RD_FALL);
   assign wrFire = wrHit && wrEnS && wrGateS;
   assign rdFire = rdHit && rdEnS && rdGateS;

   // Write port input registers, loaded on the active edge only
   always_ff @(posedge clk) begin
      if (srst) begin
         wrGo_r   <= 1'h0;
         wrAddr_r <= '0;
         wrData_r <= '0;
         wrMask_r <= '0;
      end else begin
         wrGo_r <= wrFire;
         if (wrFire) begin
            wrAddr_r <= wrAddrS;
            wrData_r <= wrDataS;
            wrMask_r <= HAS_MASK ? wrMaskS : '0;
         end
      end
   end

   // Read port input registers
   always_ff @(posedge clk) begin
      if (srst) begin
         rdGo_r   <= 1'h0;
         rdAddr_r <= '0;
      end else begin
         rdGo_r <= rdFire;
         if (rdFire) begin
            rdAddr_r <= rdAddrS;
         end
      end
   end

   // Masked merge; narrow shapes see an all-write mask
   assign wrPeek = mem[wrAddr_r];
   assign wrWord = (wrPeek & wrMask_r) | (wrData_r & ~wrMask_r);

   // Array write; a held-low enable makes the block a ROM
   always_ff @(posedge clk) begin
      if (wrGo_r) begin
         mem[wrAddr_r] <= wrWord;
      end
   end

   // Read data; same-cycle write to that word returns the old word
   always_ff @(posedge clk) begin
      if (srst) begin
         rdData_r <= RD_RESET[DATA_W-1:0];
      end else if (rdGo_r) begin
         rdData_r <= mem[rdAddr_r];
      end
   end

   assign rdData = rdData_r;
   assign rdPeek = mem[rdAddrS];

   // Checks of the port timing and the array contents
   property p_wr_gate;
      @(posedge clk) disable iff (srst)
      !(wrHit && wrEnS && wrGateS) |=> !wrGo_r;
   endproperty
   a_wr_gate: assert property (p_wr_gate)
      else $error("write started without enable and gate");

   property p_mem_keep;
      @(posedge clk) disable iff (srst)
      !wrGo_r |=> mem[$past(wrAddr_r)] == $past(wrPeek);
   endproperty
   a_mem_keep: assert property (p_mem_keep)
      else $error("array word changed with no write");

   property p_rd_hold;
      @(posedge clk) disable iff (srst)
      !rdGo_r |=> $stable(rdData_r);
   endproperty
   a_rd_hold: assert property (p_rd_hold)
      else $error("read data moved without a read");

   property p_wr_capture;
      @(posedge clk) disable iff (srst)
      wrFire |=> wrGo_r && wrAddr_r == $past(wrAddrS) && wrData_r == $past(wrDataS);
   endproperty
   a_wr_capture: assert property (p_wr_capture)
      else $error("write address or data not captured");

   property p_masked_write;
      @(posedge clk) disable iff (srst)
      wrFire ##1 1'b1 |=> mem[$past(wrAddrS, 2)] ==
         (HAS_MASK ? (($past(wrPeek) & $past(wrMaskS, 2)) |
                      ($past(wrDataS, 2) & ~$past(wrMaskS, 2)))
                   : $past(wrDataS, 2));
   endproperty
   a_masked_write: assert property (p_masked_write)
      else $error("written word does not match data and mask");

   property p_read_word;
      @(posedge clk) disable iff (srst)
      rdFire && !wrGo_r |=> ##1 rdData_r == $past(rdPeek, 2);
   endproperty
   a_read_word: assert property (p_read_word)
      else $error("read data is not the addressed word");

   property p_wr_edge;
      @(posedge clk) disable iff (srst)
      wrHit |-> wrClkS == !WR_FALL && wrPrev_r == WR_FALL;
   endproperty
   a_wr_edge: assert property (p_wr_edge)
      else $error("write acted on the wrong clock edge");

   property p_rd_edge;
      @(posedge clk) disable iff (srst)
      rdHit |-> rdClkS == !RD_FALL && rdPrev_r == RD_FALL;
   endproperty
   a_rd_edge: assert property (p_rd_edge)
      else $error("read acted on the wrong clock edge");

   property p_rd_latency;
      @(posedge clk) disable iff (srst)
      rdFire |=> rdGo_r && rdAddr_r == $past(rdAddrS);
   endproperty
   a_rd_latency: assert property (p_rd_latency)
      else $error("read not started or address not captured");

   // Capture registers move only on an accepted edge
   property p_wr_regs_hold;
      @(posedge clk) disable iff (srst)
      !wrFire |=> $stable(wrAddr_r) && $stable(wrData_r);
   endproperty
   a_wr_regs_hold: assert property (p_wr_regs_hold)
      else $error("write capture registers moved without an edge");

   property p_rd_addr_hold;
      @(posedge clk) disable iff (srst)
      !rdFire |=> $stable(rdAddr_r);
   endproperty
   a_rd_addr_hold: assert property (p_rd_addr_hold)
      else $error("read address register moved without an edge");

   // Narrow shapes must never keep a bit through the mask
   property p_narrow_mask;
      @(posedge clk) disable iff (srst)
      wrGo_r |-> HAS_MASK || wrMask_r == '0;
   endproperty
   a_narrow_mask: assert property (p_narrow_mask)
      else $error("narrow shape applied a write mask");

   property p_rd_refused;
      @(posedge clk) disable iff (srst)
      rdHit && !(rdEnS && rdGateS) |=> !rdGo_r;
   endproperty
   a_rd_refused: assert property (p_rd_refused)
      else $error("read started without enable and gate");

endmodule : dcbr_block_ram

/* File: sim/dcbr_fabric_model.sv */
// Purpose: Fabric user logic that drives both memory ports.
// Assumes: Tasks are entered just after a clk rising edge.
// Notes:   Released address, data and mask lines show the inverse of their last value; enable and gate drop low.
`timescale 1ns/1ps

module dcbr_fabric_model #(
   parameter int AW = 8,
   parameter int DW = 16
) (
   input  wire logic        clk,
   output logic             wrClock     = 1'h0,
   output logic             wrClockGate = 1'h0,
   output logic             wrEnable    = 1'h0,
   output logic [AW-1:0]    wrLocation  = '0,
   output logic [DW-1:0]    wrData      = '0,
   output logic [DW-1:0]    wrMask      = '0,
   output logic             rdClock     = 1'h0,
   output logic             rdClockGate = 1'h0,
   output logic             rdEnable    = 1'h0,
   output logic [AW-1:0]    rdLocation  = '0
);

   // Port levels held three clk periods, above the two the sampler needs
   task automatic hold3();
      repeat (3) @(posedge clk);
      #1;
   endtask : hold3

   // One write cycle; controls drop once the edge is long past
   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d, input logic [DW-1:0] m,
                     input logic en, input logic gate);
      wrLocation  = a;
      wrData      = d;
      wrMask      = m;
      wrEnable    = en;
      wrClockGate = gate;
      hold3();
      wrClock = 1'h1;
      hold3();
      wrClock = 1'h0;
      hold3();
      wrEnable    = 1'h0;
      wrClockGate = 1'h0;
      wrLocation  = ~wrLocation;
      wrData      = ~wrData;
      wrMask      = ~wrMask;
      // Released lines stand one edge, so no line is set twice at once
      @(posedge clk);
      #1;
   endtask : wr

   // One read cycle; write controls stay inactive meanwhile
   task automatic rd(input logic [AW-1:0] a, input logic en, input logic gate);
      rdLocation  = a;
      rdEnable    = en;
      rdClockGate = gate;
      hold3();
      rdClock = 1'h1;
      hold3();
      rdClock = 1'h0;
      hold3();
      rdEnable    = 1'h0;
      rdClockGate = 1'h0;
      rdLocation  = ~rdLocation;
      // Falling-edge reads land three edges later than rising ones, on this edge
      @(posedge clk);
      #1;
   endtask : rd

endmodule : dcbr_fabric_model

/* File: sim/dual_clock_block_ram_tb.sv */
// Purpose: Self-checking bench of 256x16 plain and 512x8 falling-edge memories.
// Assumes: Read data settles within the model's read cycle.
// Notes:   Preload alternates two words so address faults show.
`timescale 1ns/1ps

module dual_clock_block_ram_tb
   import dcbr_pkg::*;
;
   localparam logic [TOTAL_BITS-1:0] IMG = {128{16'h5a0f, 16'ha5c3}};
   logic        clk = 1'h0;
   logic        srst = 1'h1;
   logic        wrClock, wrClockGate, wrEnable, rdClock, rdClockGate, rdEnable;
   logic [7:0]  wrLocation, rdLocation;
   logic [15:0] wrData, wrMask, rdData;
   logic        wrClockN, wrClockGateN, wrEnableN, rdClockN, rdClockGateN, rdEnableN;
   logic [8:0]  wrLocationN, rdLocationN;
   logic [7:0]  wrDataN, wrMaskN, rdDataN;
   int          err_count = 0;
   int          tests_run = 0;

   dcbr_block_ram #(.DATA_W(WIDTH_X16), .VARIANT(VAR_PLAIN), .INIT_IMAGE(IMG)) dut (
      .clk(clk), .srst(srst), .wrClock(wrClock), .wrClockGate(wrClockGate),
      .wrEnable(wrEnable), .wrLocation(wrLocation), .wrData(wrData), .wrMask(wrMask),
      .rdClock(rdClock), .rdClockGate(rdClockGate), .rdEnable(rdEnable),
      .rdLocation(rdLocation), .rdData(rdData));

   dcbr_fabric_model fabric (
      .clk(clk), .wrClock(wrClock), .wrClockGate(wrClockGate), .wrEnable(wrEnable),
      .wrLocation(wrLocation), .wrData(wrData), .wrMask(wrMask), .rdClock(rdClock),
      .rdClockGate(rdClockGate), .rdEnable(rdEnable), .rdLocation(rdLocation));

   // Narrow shape on falling edges of both port clocks
   dcbr_block_ram #(.DATA_W(WIDTH_X8), .VARIANT(VAR_FALL_BOTH), .INIT_IMAGE(IMG)) dutNarrow (
      .clk(clk), .srst(srst), .wrClock(wrClockN), .wrClockGate(wrClockGateN),
      .wrEnable(wrEnableN), .wrLocation(wrLocationN), .wrData(wrDataN), .wrMask(wrMaskN),
      .rdClock(rdClockN), .rdClockGate(rdClockGateN), .rdEnable(rdEnableN),
      .rdLocation(rdLocationN), .rdData(rdDataN));

   dcbr_fabric_model #(.AW(9), .DW(8)) fabricN (
      .clk(clk), .wrClock(wrClockN), .wrClockGate(wrClockGateN), .wrEnable(wrEnableN),
      .wrLocation(wrLocationN), .wrData(wrDataN), .wrMask(wrMaskN), .rdClock(rdClockN),
      .rdClockGate(rdClockGateN), .rdEnable(rdEnableN), .rdLocation(rdLocationN));

   // 100 MHz system clock
   initial begin
      forever #5 clk = ~clk;
   end

   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask : check

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : test_done

   // Preloaded words read back, no write ever issued
   task automatic t_preload();
      fabric.rd(8'h07, 1'h1, 1'h1);
      check(rdData, 16'h5a0f, "preload odd");
      fabric.rd(8'h08, 1'h1, 1'h1);
      check(rdData, 16'ha5c3, "preload even");
   endtask : t_preload

   // Lowest word 00, word 10 and highest word ff written, then read back
   task automatic t_wr_rd();
      logic [7:0]  a [3];
      logic [15:0] d [3];
      a = '{8'h00, 8'h10, 8'hff};
      d = '{16'h1111, 16'h3c5a, 16'hfedc};
      foreach (a[i]) fabric.wr(a[i], d[i], 16'h0000, 1'h1, 1'h1);
      foreach (a[i]) begin
         fabric.rd(a[i], 1'h1, 1'h1);
         check(rdData, d[i], "write then read");
      end
   endtask : t_wr_rd

   // Mask ones keep the low byte; only the high byte takes the new value
   task automatic t_mask();
      fabric.wr(8'h10, 16'hffff, 16'h00ff, 1'h1, 1'h1);
      fabric.rd(8'h10, 1'h1, 1'h1);
      check(rdData, 16'hff5a, "masked write");
   endtask : t_mask

   // Write with enable or gate low leaves the word alone
   task automatic t_refuse();
      fabric.wr(8'h10, 16'h0000, 16'h0000, 1'h0, 1'h1);
      fabric.wr(8'h10, 16'h0000, 16'h0000, 1'h1, 1'h0);
      fabric.rd(8'h10, 1'h1, 1'h1);
      check(rdData, 16'hff5a, "refused write");
   endtask : t_refuse

   // Narrow falling-edge shape: preload, ignored mask, full address, hold
   task automatic t_narrow();
      fabricN.rd(9'h007, 1'h1, 1'h1);
      check({8'h00, rdDataN}, 16'h005a, "narrow preload");
      fabricN.wr(9'h1ff, 8'h3c, 8'hff, 1'h1, 1'h1);
      fabricN.rd(9'h1ff, 1'h1, 1'h1);
      check({8'h00, rdDataN}, 16'h003c, "narrow mask ignored");
      fabricN.rd(9'h0ff, 1'h1, 1'h1);
      check({8'h00, rdDataN}, 16'h005a, "narrow top address bit");
      fabricN.rd(9'h108, 1'h0, 1'h1);
      check({8'h00, rdDataN}, 16'h005a, "narrow read enable low");
   endtask : t_narrow

   // Read with enable or gate low keeps the old read data
   task automatic t_hold();
      fabric.rd(8'h00, 1'h1, 1'h1);
      fabric.rd(8'hff, 1'h0, 1'h1);
      check(rdData, 16'h1111, "read enable low");
      fabric.rd(8'hff, 1'h1, 1'h0);
      check(rdData, 16'h1111, "read gate low");
      fabric.rd(8'hff, 1'h1, 1'h1);
      check(rdData, 16'hfedc, "read after hold");
   endtask : t_hold

   // Hang guard
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      test_done();
   end

   // Reset for four cycles, settle, then the scenarios
   initial begin
      repeat (4) @(posedge clk);
      #1;
      srst = 1'h0;
      repeat (5) @(posedge clk);
      #1;
      check(rdData, RD_RESET, "reset value");
      check({8'h00, rdDataN}, RD_RESET, "narrow reset value");
      t_preload();
      t_wr_rd();
      t_mask();
      t_refuse();
      t_hold();
      t_narrow();
      test_done();
   end

endmodule : dual_clock_block_ram_tb
